// ### design/fie_fault_irq_enable.sv
// fie_fault_irq_enable: enable masking of group-two and group-three fault
// sources onto the active-low interrupt request, with a wishbone slave.
// assumes fault inputs are asynchronous levels; bus is classic wishbone.
//
// Summary of operation
// - enable 0 blocks its status bit from the request, 1 lets it through
// - group-two enable bit 10 gates pin overvoltage status two bit 10
// - group-two enable bit 9 gates analog undervoltage status two bit 9
// - group-two enable bit 8 gates bus transfer failure status two bit 8
// - writes to read-only registers are refused and flagged in config and status
// - group-two enable bit 7 gates watchdog timeout; expiry sets status two bit 7
// - pin signalling needs interrupt protocol selected and volatile mode off
// - group-two enable bit 6 gates seal ring break status two bit 6
// - group-two enable bit 5 gates state machine error, status three bit 1
// - group-two enable bit 4 gates output common-mode fault status two bit 4
// - group-two enable bit 3 gates output overcurrent status two bit 3
// - group-two enable bit 2 gates digital overvoltage, status three bit 4
// - group-two enable bit 1 gates gain loop range error, status three bit 3
// - group-two enable bit 0 gates receiver path fault status two bit 0
// - group-three enable bit 1 gates transmitter coil fault, status three bit 0
// - group-three enable bit 0 gates self-test failure, status three bit 2
// - top four bits of each enable word hold the correction check word
// - bit 11 of each enable word holds the double-error parity bit
// - watchdog timeout is 584 us times one plus the 11-bit setting
`default_nettype none

module fie_fault_irq_enable
  import fie_pkg::*;
#(
  parameter int unsigned WDG_STEP_CYCLES = FIE_WDG_STEP_CYCLES,
  parameter int          ADR_W           = 10
) (
  // clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  // wishbone slave
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [ADR_W-1:0]       wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic                        wb_ack_o,
  output logic [31:0]                 wb_dat_o,
  // fault sources, asynchronous levels
  input  wire logic [FIE_STAT2_W-1:0] fault_two_i,
  input  wire logic [FIE_STAT3_W-1:0] fault_three_i,
  // interrupt request
  output logic                        irq_n_o,
  output logic                        adr_irq_o,
  output logic                        adr_irq_oe_o
);

  localparam int FLT_W = FIE_STAT2_W + FIE_STAT3_W;

  // hamming check over the 11 data bits plus an overall parity bit
  function automatic logic [FIE_WORD_W-1:0] protect(input logic [FIE_DATA_W-1:0] d);
    logic [3:0] c;
    int         j;
    c = 4'h0;
    j = 0;
    for (int k = 3; k < 16; k++) begin
      if ((k & (k - 1)) != 0) begin
        for (int b = 0; b < 4; b++) begin
          if (k[b]) begin
            c[b] = c[b] ^ d[j];
          end
        end
        j = j + 1;
      end
    end
    return {c, ^{c, d}, d};
  endfunction

  // byte-lane merge of a write into an 11-bit data field
  function automatic logic [FIE_DATA_W-1:0] merge(input logic [FIE_DATA_W-1:0] old,
                                                  input logic [31:0]           wd,
                                                  input logic [3:0]            sel);
    logic [FIE_DATA_W-1:0] r;
    r = old;
    if (sel[0]) begin
      r[7:0] = wd[7:0];
    end
    if (sel[1]) begin
      r[10:8] = wd[10:8];
    end
    return r;
  endfunction

  // ---------------- fault input synchronisers ----------------
  logic [FLT_W-1:0] sync1_reg;
  logic [FLT_W-1:0] sync2_reg;
  logic [FLT_W-1:0] sync3_reg;
  logic [FLT_W-1:0] flt_reg;
  logic [FLT_W-1:0] flt_next;

  // a change is taken only once the second and third stages agree; the first
  // stage may settle late and only the second reads it, and a glitch shorter
  // than a cycle never reaches the status latches
  assign flt_next = (sync2_reg & sync3_reg) | (flt_reg & (sync2_reg | sync3_reg));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
      flt_reg   <= '0;
    end else begin
      sync1_reg <= {fault_three_i, fault_two_i};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      flt_reg   <= flt_next;
    end
  end

  // ---------------- bus decode ----------------
  logic       ack_reg;
  logic [31:0] dat_reg;

  wire [7:0] idx     = wb_adr_i[ADR_W-1:2];
  // a held request is taken once: ack_reg blocks the cycle after it
  wire       access  = wb_cyc_i && wb_stb_i && !ack_reg;
  wire       wr      = access && wb_we_i;

  wire hit_nv2   = (idx == FIE_IDX_NV_EN_TWO);
  wire hit_nv3   = (idx == FIE_IDX_NV_EN_THREE);
  wire hit_sh2   = (idx == FIE_IDX_SH_EN_TWO);
  wire hit_sh3   = (idx == FIE_IDX_SH_EN_THREE);
  wire hit_wdg   = (idx == FIE_IDX_WDG_TIME);
  wire hit_cfg   = (idx == FIE_IDX_SYS_CFG_TWO);
  wire hit_st2   = (idx == FIE_IDX_STAT_TWO);
  wire hit_st3   = (idx == FIE_IDX_STAT_THREE);
  wire hit_clr2  = (idx == FIE_IDX_CLR_TWO);
  wire hit_clr3  = (idx == FIE_IDX_CLR_THREE);

  // status words are read-only; a write to them is a transfer failure
  // the write data itself is dropped; only the flag and status bit record it
  wire apb_fail_ev = wr && (hit_st2 || hit_st3);

  // ---------------- enable words ----------------
  // nonvolatile copies are stored and read back but do not gate the request
  logic [FIE_WORD_W-1:0] nv2_reg;
  logic [FIE_WORD_W-1:0] nv3_reg;
  logic [FIE_WORD_W-1:0] sh2_reg;
  logic [FIE_WORD_W-1:0] sh3_reg;

  // check bits are recomputed on every write, never taken from the bus
  // no correction is done here; the check bits only travel with the word
  wire [FIE_WORD_W-1:0] nv2_next = protect(merge(nv2_reg[FIE_DATA_W-1:0], wb_dat_i, wb_sel_i));
  wire [FIE_WORD_W-1:0] nv3_next = protect(merge(nv3_reg[FIE_DATA_W-1:0], wb_dat_i, wb_sel_i));
  wire [FIE_WORD_W-1:0] sh2_next = protect(merge(sh2_reg[FIE_DATA_W-1:0], wb_dat_i, wb_sel_i));
  // shadow group three holds only two writable data bits; the other data bits read zero
  wire [FIE_DATA_W-1:0] sh3_data = {{(FIE_DATA_W - FIE_EN3_W){1'b0}},
                                    (wb_sel_i[0] ? wb_dat_i[FIE_EN3_W-1:0]
                                                 : sh3_reg[FIE_EN3_W-1:0])};
  wire [FIE_WORD_W-1:0] sh3_next = protect(sh3_data);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nv2_reg <= FIE_EN_RESET;
      nv3_reg <= FIE_EN_RESET;
      sh2_reg <= FIE_EN_RESET;
      sh3_reg <= FIE_EN_RESET;
    end else begin
      if (wr && hit_nv2) begin
        nv2_reg <= nv2_next;
      end
      if (wr && hit_nv3) begin
        nv3_reg <= nv3_next;
      end
      if (wr && hit_sh2) begin
        sh2_reg <= sh2_next;
      end
      if (wr && hit_sh3) begin
        sh3_reg <= sh3_next;
      end
    end
  end

  // ---------------- configuration ----------------
  logic [FIE_WDG_SET_W-1:0] wdg_set_reg;
  logic                     wdg_en_reg;
  logic                     proto_irq_reg;
  logic                     vol_mode_reg;
  logic                     apb_flag_reg;

  // a configuration write uses lane 0 only; the other lanes hold nothing here
  wire cfg_wr = wr && hit_cfg;
  // set wins over a write-one clear arriving in the same cycle
  wire apb_flag_next = apb_fail_ev ||
                       (apb_flag_reg && !(cfg_wr && wb_sel_i[0] && wb_dat_i[FIE_CFG_APB_FAIL]));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdg_set_reg   <= FIE_WDG_RESET;
      wdg_en_reg    <= 1'b0;
      proto_irq_reg <= 1'b0;
      vol_mode_reg  <= 1'b0;
      apb_flag_reg  <= 1'b0;
    end else begin
      if (wr && hit_wdg) begin
        wdg_set_reg <= merge(wdg_set_reg, wb_dat_i, wb_sel_i);
      end
      if (cfg_wr && wb_sel_i[0]) begin
        wdg_en_reg    <= wb_dat_i[FIE_CFG_WDG_EN];
        proto_irq_reg <= wb_dat_i[FIE_CFG_PROTO_IRQ];
        vol_mode_reg  <= wb_dat_i[FIE_CFG_VOL_MODE];
      end
      apb_flag_reg <= apb_flag_next;
    end
  end

  // ---------------- watchdog ----------------
  logic wdg_expire;

  // any bus access by the host counts as servicing the watchdog, so a host
  // that polls status keeps it quiet; a watchdog enabled again starts a full
  // period
  fie_wdg_timer #(
    .STEP_CYCLES (WDG_STEP_CYCLES)
  ) u_wdg (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .enable_i  (wdg_en_reg),
    .restart_i (access),
    .setting_i (wdg_set_reg),
    .expire_o  (wdg_expire)
  );

  // ---------------- latched fault status ----------------
  logic [FIE_STAT2_W-1:0] st2_reg;
  logic [FIE_STAT3_W-1:0] st3_reg;

  wire [FIE_STAT2_W-1:0] ev2;
  wire [FIE_STAT2_W-1:0] clr2;
  wire [FIE_STAT3_W-1:0] clr3;

  // bits 8 and 7 come from this block; the pins for them are ignored
  assign ev2 = {flt_reg[10:9],
                apb_fail_ev,
                wdg_expire,
                flt_reg[6:0]};
  assign clr2 = (wr && hit_clr2) ? merge('0, wb_dat_i, wb_sel_i) : '0;
  assign clr3 = (wr && hit_clr3 && wb_sel_i[0]) ? wb_dat_i[FIE_STAT3_W-1:0] : '0;

  // a fault still present sets its bit again at once, so a clear only
  // sticks once the source has gone; set wins over clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st2_reg <= FIE_STAT_RESET;
      st3_reg <= FIE_STAT_RESET[FIE_STAT3_W-1:0];
    end else begin
      st2_reg <= (st2_reg & ~clr2) | ev2;
      st3_reg <= (st3_reg & ~clr3) | flt_reg[FLT_W-1:FIE_STAT2_W];
    end
  end

  // ---------------- enable gating ----------------
  wire [FIE_DATA_W-1:0] en2 = sh2_reg[FIE_DATA_W-1:0];
  wire [FIE_EN3_W-1:0]  en3 = sh3_reg[FIE_EN3_W-1:0];

  // status bit steered to each group-two enable position
  wire [FIE_DATA_W-1:0] src2;
  assign src2[10] = st2_reg[10];
  assign src2[9]  = st2_reg[9];
  assign src2[8]  = st2_reg[8];
  assign src2[7]  = st2_reg[7];
  assign src2[6]  = st2_reg[6];
  assign src2[5]  = st3_reg[1];
  assign src2[4]  = st2_reg[4];
  assign src2[3]  = st2_reg[3];
  assign src2[2]  = st3_reg[4];
  assign src2[1]  = st3_reg[3];
  assign src2[0]  = st2_reg[0];

  wire [FIE_EN3_W-1:0] src3;
  assign src3[1] = st3_reg[0];
  assign src3[0] = st3_reg[2];

  wire pend2     = |(en2 & src2);
  wire pend3     = |(en3 & src3);
  wire pending   = pend2 || pend3;
  // the pin follows the request only in interrupt protocol with volatile mode off
  wire pin_route = proto_irq_reg && !vol_mode_reg;

  logic irq_n_reg;
  logic pin_oe_reg;
  logic pin_val_reg;

  // the pin value is a constant low, kept in a flop so every output leaves a register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_n_reg   <= 1'b1;
      pin_oe_reg  <= 1'b0;
      pin_val_reg <= 1'b0;
    end else begin
      irq_n_reg   <= !pending;
      pin_oe_reg  <= pending && pin_route;
      pin_val_reg <= 1'b0;
    end
  end

  // ---------------- read data and acknowledge ----------------
  wire [31:0] cfg_word = {25'h0000000, apb_flag_reg, 3'h0,
                          vol_mode_reg, proto_irq_reg, wdg_en_reg};

  // unmapped addresses are acknowledged and read as zero
  // read data is held between reads, so a slow master may still take it
  wire [31:0] rd_word =
    hit_nv2 ? {16'h0000, nv2_reg} :
    hit_nv3 ? {16'h0000, nv3_reg} :
    hit_sh2 ? {16'h0000, sh2_reg} :
    hit_sh3 ? {16'h0000, sh3_reg} :
    hit_wdg ? {21'h000000, wdg_set_reg} :
    hit_cfg ? cfg_word :
    hit_st2 ? {21'h000000, st2_reg} :
    hit_st3 ? {27'h0000000, st3_reg} :
    32'h00000000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h00000000;
    end else begin
      ack_reg <= access;
      if (access && !wb_we_i) begin
        dat_reg <= rd_word;
      end
    end
  end

  assign wb_ack_o     = ack_reg;
  assign wb_dat_o     = dat_reg;
  assign irq_n_o      = irq_n_reg;
  // open-drain: the pin is only ever pulled low
  assign adr_irq_o    = pin_val_reg;
  assign adr_irq_oe_o = pin_oe_reg;

endmodule

`default_nettype wire

// ### design/fie_pkg.sv
// fie_pkg: constants shared by the fault interrupt enable block.
// assumes a 10 MHz system clock and a 32-bit classic wishbone register bus.
`default_nettype none

package fie_pkg;

  // register indices; the byte address on the bus is four times the index
  localparam logic [7:0] FIE_IDX_NV_EN_TWO   = 8'h0C;
  localparam logic [7:0] FIE_IDX_NV_EN_THREE = 8'h0D;
  localparam logic [7:0] FIE_IDX_SH_EN_TWO   = 8'h4C;
  localparam logic [7:0] FIE_IDX_SH_EN_THREE = 8'h4D;
  localparam logic [7:0] FIE_IDX_WDG_TIME    = 8'h4E;
  localparam logic [7:0] FIE_IDX_SYS_CFG_TWO = 8'h50;
  localparam logic [7:0] FIE_IDX_STAT_TWO    = 8'h51;
  localparam logic [7:0] FIE_IDX_STAT_THREE  = 8'h52;
  localparam logic [7:0] FIE_IDX_CLR_TWO     = 8'h53;
  localparam logic [7:0] FIE_IDX_CLR_THREE   = 8'h54;

  // enable word layout
  localparam int FIE_ECC_MSB  = 15;
  localparam int FIE_ECC_LSB  = 12;
  localparam int FIE_DED_BIT  = 11;
  localparam int FIE_DATA_W   = 11;
  localparam int FIE_WORD_W   = 16;
  localparam int FIE_STAT2_W  = 11;
  localparam int FIE_STAT3_W  = 5;
  localparam int FIE_EN3_W    = 2;

  // group-two status bits raised inside this block
  localparam int FIE_ST2_APB_FAIL = 8;
  localparam int FIE_ST2_WDG      = 7;

  // system configuration two fields
  localparam int FIE_CFG_WDG_EN     = 0;
  localparam int FIE_CFG_PROTO_IRQ  = 1;
  localparam int FIE_CFG_VOL_MODE   = 2;
  localparam int FIE_CFG_APB_FAIL   = 6;

  // reset values
  localparam logic [15:0] FIE_EN_RESET   = 16'h0000;
  localparam logic [10:0] FIE_WDG_RESET  = 11'h000;
  localparam logic [10:0] FIE_STAT_RESET = 11'h000;

  // watchdog timing: one step of the timer setting
  localparam int unsigned FIE_CLK_PERIOD_NS = 100;
  localparam int unsigned FIE_WDG_STEP_NS   = 584000;
  localparam int unsigned FIE_WDG_STEP_CYCLES =
    (FIE_WDG_STEP_NS / FIE_CLK_PERIOD_NS < 1) ? 1 : FIE_WDG_STEP_NS / FIE_CLK_PERIOD_NS;
  localparam int FIE_WDG_SET_W = 11;

endpackage

`default_nettype wire

// ### design/fie_wdg_timer.sv
// fie_wdg_timer: interrupt watchdog, expires (setting + 1) steps after restart.
// assumes restart is a same-clock pulse from the bus slave.
`default_nettype none

module fie_wdg_timer
  import fie_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = FIE_WDG_STEP_CYCLES
) (
  // clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  // control
  input  wire logic                     enable_i,
  input  wire logic                     restart_i,
  input  wire logic [FIE_WDG_SET_W-1:0] setting_i,
  // result
  output logic                          expire_o
);

  localparam int PRE_W = $clog2(STEP_CYCLES + 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(STEP_CYCLES - 1);

  logic [PRE_W-1:0]         pre_reg;
  logic [FIE_WDG_SET_W-1:0] step_reg;
  logic                     expire_reg;

  wire step_done = (pre_reg == PRE_LAST);
  wire all_done  = step_done && (step_reg == setting_i);
  wire hold      = !enable_i || restart_i;

  // a disabled or restarted timer starts a fresh full period
  always_ff @(posedge clk_i) begin
    if (rst_i || hold || all_done) begin
      pre_reg  <= '0;
      step_reg <= '0;
    end else if (step_done) begin
      pre_reg  <= '0;
      step_reg <= step_reg + 1'b1;
    end else begin
      pre_reg  <= pre_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      expire_reg <= 1'b0;
    end else begin
      expire_reg <= !hold && all_done;
    end
  end

  assign expire_o = expire_reg;

endmodule

`default_nettype wire

// ### verif/fie_checker.sv
// fie_checker: port-level properties of the fault interrupt enable block.
// assumes it is bound to the top module and sees only its ports.
`default_nettype none

module fie_checker
  import fie_pkg::*;
#(
  parameter int unsigned WDG_STEP_CYCLES = FIE_WDG_STEP_CYCLES,
  parameter int          ADR_W           = 10
) (
  // clock and reset
  input wire logic                   clk_i,
  input wire logic                   rst_i,
  // wishbone slave
  input wire logic                   wb_cyc_i,
  input wire logic                   wb_stb_i,
  input wire logic                   wb_we_i,
  input wire logic [ADR_W-1:0]       wb_adr_i,
  input wire logic [3:0]             wb_sel_i,
  input wire logic [31:0]            wb_dat_i,
  input wire logic                   wb_ack_o,
  input wire logic [31:0]            wb_dat_o,
  // faults and request
  input wire logic [FIE_STAT2_W-1:0] fault_two_i,
  input wire logic [FIE_STAT3_W-1:0] fault_three_i,
  input wire logic                   irq_n_o,
  input wire logic                   adr_irq_o,
  input wire logic                   adr_irq_oe_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged in the next cycle");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_needs_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_reset_quiet: assert property (@(posedge clk_i) disable iff (1'b0)
    rst_i |=> irq_n_o && !wb_ack_o && !adr_irq_oe_o && wb_dat_o == 32'h0)
    else $error("outputs not quiet after reset");
  a_pin_needs_irq: assert property (adr_irq_oe_o |-> !irq_n_o)
    else $error("pin driven with no pending request");
  a_pin_pull_low: assert property (!adr_irq_o)
    else $error("pin value not low");
  // a request only goes away through a clear or enable write, or reset
  a_irq_release: assert property ($rose(irq_n_o) |->
    $past(wb_ack_o) || $past(wb_ack_o, 2) || $past(wb_ack_o, 3) || $past(rst_i))
    else $error("request released without a bus write");
  a_dat_hold: assert property ($changed(wb_dat_o) |-> wb_ack_o || $past(rst_i))
    else $error("read data changed outside ack");

  c_irq_fall: cover property ($fell(irq_n_o));
  c_pin_drive: cover property ($rose(adr_irq_oe_o));
  c_write: cover property (wb_ack_o && wb_we_i);
endmodule

bind fie_fault_irq_enable fie_checker #(
  .WDG_STEP_CYCLES(WDG_STEP_CYCLES),
  .ADR_W(ADR_W)
) i_fie_checker (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_sel_i, .wb_dat_i, .wb_ack_o, .wb_dat_o, .fault_two_i, .fault_three_i,
  .irq_n_o, .adr_irq_o, .adr_irq_oe_o);

`default_nettype wire

// ### verif/fie_host_model.sv
// fie_host_model: host watching the request line and the shared pin.
// assumes an external pull-up on the pin; the host never drives it.
`default_nettype none

module fie_host_model (
  // clock
  input  wire logic clk_i,
  // request and pin
  input  wire logic irq_n_i,
  input  wire logic pin_i,
  input  wire logic pin_oe_i,
  // observed
  output logic      pin_o,
  output int        falls_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic irq_q = 1'b1;
  // a released pin floats up, so the last driven value never lingers
  assign pin_o = pin_oe_i ? pin_i : 1'b1;
  initial falls_o = 0;
  always @(posedge clk_i) begin
    irq_q <= irq_n_i;
    if (irq_q === 1'b1 && irq_n_i === 1'b0) falls_o <= falls_o + 1;
  end
endmodule

`default_nettype wire

// ### verif/tb_top.sv
// tb_top: self-checking bench for the fault interrupt enable block.
// assumes the package, checker and host model are compiled first.
`default_nettype none

module tb_top;
  import fie_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic [9:0]  adr   = 10'h000;
  logic [31:0] dat   = 32'h0;
  logic [10:0] f2    = 11'h000;
  logic [4:0]  f3    = 5'h00;
  logic        ack, irq_n, pin_a, pin_oe, pin;
  logic [31:0] rdat, rd;
  int          falls;
  int          bad_count = 0;
  int          tests_run = 0;
  int          mb [11] = '{10, 9, 6, 5, 4, 3, 2, 1, 0, 1, 0};
  int          ms [11] = '{10, 9, 6, 12, 4, 3, 15, 14, 0, 11, 13};

  always #50 clk_i = ~clk_i;

  fie_fault_irq_enable #(.WDG_STEP_CYCLES(4), .ADR_W(10)) i_fie_fault_irq_enable (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_ack_o(ack), .wb_dat_o(rdat),
    .fault_two_i(f2), .fault_three_i(f3), .irq_n_o(irq_n), .adr_irq_o(pin_a),
    .adr_irq_oe_o(pin_oe));
  fie_host_model i_fie_host_model (.clk_i(clk_i), .irq_n_i(irq_n), .pin_i(pin_a),
    .pin_oe_i(pin_oe), .pin_o(pin), .falls_o(falls));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    check({31'h0, got}, {31'h0, exp});
  endtask

  // called just after a rising edge; waits for ack, only the watchdog ends a hang
  task automatic wb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    dat <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    chk1(ack, 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask

  function automatic logic [15:0] ecc(input logic [10:0] d);
    logic [15:0] p;
    logic [3:0]  c;
    int          k;
    p = 16'h0000;
    c = 4'h0;
    k = 0;
    for (int q = 3; q < 16; q++)
      if (q != 4 && q != 8) begin
        p[q] = d[k];
        k++;
      end
    for (int b = 0; b < 4; b++)
      for (int q = 3; q < 16; q++)
        if (q[b]) c[b] ^= p[q];
    return {c, ^{c, d}, d};
  endfunction

  task automatic t_reset();
    logic [7:0] ri [5] = '{FIE_IDX_NV_EN_TWO, FIE_IDX_NV_EN_THREE, FIE_IDX_SH_EN_TWO,
                           FIE_IDX_SH_EN_THREE, 8'h20};
    wb(1'b1, 8'h20, 32'h7FF);
    foreach (ri[i]) begin
      wb(1'b0, ri[i], 32'h0);
      check(rd, 32'h0);
    end
    chk1(irq_n, 1'b1);
    chk1(pin, 1'b1);
    $display("reset test done");
  endtask

  task automatic t_map();
    logic [7:0] ei;
    for (int i = 0; i < 11; i++) begin
      ei = (i > 8) ? FIE_IDX_SH_EN_THREE : FIE_IDX_SH_EN_TWO;
      {f3, f2} <= 16'h1 << ms[i];
      repeat (10) @(posedge clk_i);
      chk1(irq_n, 1'b1);
      wb(1'b1, ei, 32'h1 << mb[i]);
      repeat (3) @(posedge clk_i);
      chk1(irq_n, 1'b0);
      {f3, f2} <= 16'h0;
      repeat (5) @(posedge clk_i);
      wb(1'b1, FIE_IDX_CLR_TWO, 32'h7FF);
      wb(1'b1, FIE_IDX_CLR_THREE, 32'h1F);
      repeat (3) @(posedge clk_i);
      chk1(irq_n, 1'b1);
      wb(1'b1, ei, 32'h0);
    end
    $display("enable map test done");
  endtask

  task automatic t_ro();
    wb(1'b1, FIE_IDX_STAT_TWO, 32'h7FF);
    wb(1'b0, FIE_IDX_STAT_TWO, 32'h0);
    check(rd, 32'h100);
    wb(1'b1, FIE_IDX_STAT_THREE, 32'h1F);
    wb(1'b0, FIE_IDX_STAT_THREE, 32'h0);
    check(rd, 32'h0);
    wb(1'b0, FIE_IDX_SYS_CFG_TWO, 32'h0);
    check(rd, 32'h40);
    chk1(irq_n, 1'b1);
    wb(1'b1, FIE_IDX_SH_EN_TWO, 32'h100);
    repeat (2) @(posedge clk_i);
    chk1(irq_n, 1'b0);
    wb(1'b1, FIE_IDX_CLR_TWO, 32'h100);
    wb(1'b1, FIE_IDX_SYS_CFG_TWO, 32'h40);
    wb(1'b0, FIE_IDX_SYS_CFG_TWO, 32'h0);
    check(rd, 32'h0);
    wb(1'b1, FIE_IDX_SH_EN_TWO, 32'h0);
    chk1(irq_n, 1'b1);
    $display("read-only write test done");
  endtask

  task automatic t_wdg();
    int n;
    int f0;
    n = 0;
    f0 = falls;
    wb(1'b1, FIE_IDX_WDG_TIME, 32'h3);
    wb(1'b1, FIE_IDX_SH_EN_TWO, 32'h80);
    wb(1'b1, FIE_IDX_SYS_CFG_TWO, 32'h3);
    while (irq_n !== 1'b0 && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    // four steps of four cycles; three steps would land near twelve
    chk1(n >= 14 && n <= 20, 1'b1);
    @(posedge clk_i);
    chk1(pin, 1'b0);
    chk1(falls == f0 + 1, 1'b1);
    wb(1'b1, FIE_IDX_SYS_CFG_TWO, 32'h7);
    repeat (2) @(posedge clk_i);
    chk1(pin, 1'b1);
    chk1(irq_n, 1'b0);
    wb(1'b1, FIE_IDX_SYS_CFG_TWO, 32'h0);
    wb(1'b1, FIE_IDX_CLR_TWO, 32'h80);
    repeat (2) @(posedge clk_i);
    chk1(irq_n, 1'b1);
    wb(1'b1, FIE_IDX_SH_EN_TWO, 32'h0);
    $display("watchdog test done");
  endtask

  task automatic t_ecc();
    logic [10:0] v [3] = '{11'h001, 11'h7FF, 11'h555};
    for (int i = 0; i < 3; i++) begin
      wb(1'b1, i[0] ? FIE_IDX_NV_EN_TWO : FIE_IDX_SH_EN_TWO, {21'h1FFFFF, v[i]});
      wb(1'b0, i[0] ? FIE_IDX_NV_EN_TWO : FIE_IDX_SH_EN_TWO, 32'h0);
      check(rd, {16'h0, ecc(v[i])});
    end
    wb(1'b1, FIE_IDX_SH_EN_THREE, 32'h7FF);
    wb(1'b0, FIE_IDX_SH_EN_THREE, 32'h0);
    check(rd, {16'h0, ecc(11'h003)});
    wb(1'b1, FIE_IDX_SH_EN_THREE, 32'h0);
    wb(1'b1, FIE_IDX_SH_EN_TWO, 32'h0);
    $display("check word test done");
  endtask

  task automatic end_of_test();
    $display("tests=%0d mismatches=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_map();
    t_ro();
    t_wdg();
    t_ecc();
    end_of_test();
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    end_of_test();
  end
endmodule

`default_nettype wire
